// file: hdl/dms_mult.sv
`timescale 1ns/100ps
// Overview of operation
// - Wide mode: one 18 by 18 multiplier.
// - Narrow mode: two independent 9 by 9 multipliers.
// - Sign select A high means A signed.
// - Sign select B independently chooses B signedness.
// - Product signed when either operand signed.
// - Full precision product, never truncated or rounded.
// - Narrow halves share one A and B sign.
// - Sign selects may change at run time.
// - Sign selects optionally registered with operands.
// - Input and output stages independently used or bypassed.
// - All stages share clock, enable and clear.
module dms_mult
    import dms_pkg::*;
#(
    parameter int AW = WIDE_W,
    parameter int NW = NARROW_W
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [dms_pkg::WB_AW-1:0] wb_adr_i,
    input  wire logic [dms_pkg::WB_DW-1:0] wb_dat_i,
    input  wire logic [3:0]             wb_sel_i,
    output logic      [dms_pkg::WB_DW-1:0] wb_dat_o,
    output logic                        wb_ack_o
);
    import dms_pkg::*;

    localparam int PW = 2 * AW;

    logic [CTRL_W-1:0] ctrl_r;
    logic [AW-1:0]     opa_r;
    logic [AW-1:0]     opb_r;
    logic [AW-1:0]     a_stage_r;
    logic [AW-1:0]     b_stage_r;
    logic              sa_stage_r;
    logic              sb_stage_r;
    logic [PW-1:0]     p_stage_r;
    logic              psign_stage_r;
    logic [AW-1:0]     a_use;
    logic [AW-1:0]     b_use;
    logic              sa_use;
    logic              sb_use;
    logic [PW-1:0]     p_wide;
    logic [2*NW-1:0]   p_lo;
    logic [2*NW-1:0]   p_hi;
    logic [PW-1:0]     p_comb;
    logic              psign_comb;
    logic [PW-1:0]     res_use;
    logic              psign_use;
    logic              req;
    logic              wr;
    logic              stage_ena;
    logic              stage_clr;
    logic [WB_DW-1:0]  rd_nxt;

    function automatic logic [WB_DW-1:0] merge(input logic [WB_DW-1:0] old_v,
                                               input logic [WB_DW-1:0] new_v,
                                               input logic [3:0]       sel);
        logic [WB_DW-1:0] m;
        m = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return m;
    endfunction : merge

    assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr        = req & wb_we_i;
    // One enable and one clear steer every stage; no stage has its own.
    assign stage_ena = ctrl_r[CTRL_CLK_ENA];
    assign stage_clr = ctrl_r[CTRL_CLEAR];

    // Bus interface: one wait state, ack for any address including unmapped.
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= CTRL_RESET;
        end else if (wr && wb_adr_i == OFS_CTRL) begin
            ctrl_r <= CTRL_W'(merge(WB_DW'(ctrl_r), wb_dat_i, wb_sel_i));
        end
    end

    // Operands come from the surrounding logic through these two registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            opa_r <= '0;
            opb_r <= '0;
        end else if (wr) begin
            if (wb_adr_i == OFS_OPA) begin
                opa_r <= AW'(merge(WB_DW'(opa_r), wb_dat_i, wb_sel_i));
            end else if (wb_adr_i == OFS_OPB) begin
                opb_r <= AW'(merge(WB_DW'(opb_r), wb_dat_i, wb_sel_i));
            end
        end
    end

    // Input stage holds operands; clear beats enable.
    always_ff @(posedge clk) begin
        if (rst || stage_clr) begin
            a_stage_r <= '0;
            b_stage_r <= '0;
        end else if (stage_ena) begin
            a_stage_r <= opa_r;
            b_stage_r <= opb_r;
        end
    end

    // Sign selects get their own stage so they can track the registered data.
    always_ff @(posedge clk) begin
        if (rst || stage_clr) begin
            sa_stage_r <= 1'b0;
            sb_stage_r <= 1'b0;
        end else if (stage_ena) begin
            sa_stage_r <= ctrl_r[CTRL_SIGN_A];
            sb_stage_r <= ctrl_r[CTRL_SIGN_B];
        end
    end

    assign a_use  = ctrl_r[CTRL_IN_REG] ? a_stage_r : opa_r;
    assign b_use  = ctrl_r[CTRL_IN_REG] ? b_stage_r : opb_r;
    // Signs come live from the control register, or from the sign stage when CTRL_SIGN_REG is set; a change needs no reconfiguring.
    assign sa_use = ctrl_r[CTRL_SIGN_REG] ? sa_stage_r : ctrl_r[CTRL_SIGN_A];
    assign sb_use = ctrl_r[CTRL_SIGN_REG] ? sb_stage_r : ctrl_r[CTRL_SIGN_B];

    dms_smul #(.W(AW)) u_wide (
        .a      (a_use),
        .b      (b_use),
        .sign_a (sa_use),
        .sign_b (sb_use),
        .p      (p_wide)
    );

    // Both halves see the same sign pair; mixed signs per half are not possible.
    dms_smul #(.W(NW)) u_narrow_lo (
        .a      (a_use[NW-1:0]),
        .b      (b_use[NW-1:0]),
        .sign_a (sa_use),
        .sign_b (sb_use),
        .p      (p_lo)
    );

    dms_smul #(.W(NW)) u_narrow_hi (
        .a      (a_use[2*NW-1:NW]),
        .b      (b_use[2*NW-1:NW]),
        .sign_a (sa_use),
        .sign_b (sb_use),
        .p      (p_hi)
    );

    // Narrow results stay separate: low half in bits 17:0, high half in 35:18.
    assign p_comb     = ctrl_r[CTRL_MODE_NARROW] ? {p_hi, p_lo} : p_wide;
    assign psign_comb = sa_use | sb_use;

    always_ff @(posedge clk) begin
        if (rst || stage_clr) begin
            p_stage_r     <= '0;
            psign_stage_r <= 1'b0;
        end else if (stage_ena) begin
            p_stage_r     <= p_comb;
            psign_stage_r <= psign_comb;
        end
    end

    assign res_use   = ctrl_r[CTRL_OUT_REG] ? p_stage_r : p_comb;
    assign psign_use = ctrl_r[CTRL_OUT_REG] ? psign_stage_r : psign_comb;

    always_comb begin
        rd_nxt = '0;
        if (wb_adr_i == OFS_CTRL) begin
            rd_nxt[CTRL_W-1:0] = ctrl_r;
        end else if (wb_adr_i == OFS_OPA) begin
            rd_nxt[AW-1:0] = opa_r;
        end else if (wb_adr_i == OFS_OPB) begin
            rd_nxt[AW-1:0] = opb_r;
        end else if (wb_adr_i == OFS_RES_LO) begin
            rd_nxt = res_use[WB_DW-1:0];
        end else if (wb_adr_i == OFS_RES_HI) begin
            rd_nxt[PW-WB_DW-1:0] = res_use[PW-1:WB_DW];
        end else if (wb_adr_i == OFS_STATUS) begin
            rd_nxt[STAT_RES_SIGNED] = psign_use;
            rd_nxt[STAT_MODE]       = ctrl_r[CTRL_MODE_NARROW];
            rd_nxt[STAT_CLEARING]   = stage_clr;
        end
    end

    // Read data is captured with the ack, so it is stable while ack is high.
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= '0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= rd_nxt;
        end
    end

endmodule : dms_mult

// file: hdl/dms_pkg.sv
package dms_pkg;

    localparam int WIDE_W      = 18;
    localparam int NARROW_W    = 9;
    localparam int PROD_W      = 2 * WIDE_W;
    localparam int WB_AW       = 8;
    localparam int WB_DW       = 32;

    localparam logic [WB_AW-1:0] OFS_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] OFS_OPA    = 8'h04;
    localparam logic [WB_AW-1:0] OFS_OPB    = 8'h08;
    localparam logic [WB_AW-1:0] OFS_RES_LO = 8'h0C;
    localparam logic [WB_AW-1:0] OFS_RES_HI = 8'h10;
    localparam logic [WB_AW-1:0] OFS_STATUS = 8'h14;

    localparam int CTRL_MODE_NARROW = 0;
    localparam int CTRL_SIGN_A      = 1;
    localparam int CTRL_SIGN_B      = 2;
    localparam int CTRL_IN_REG      = 3;
    localparam int CTRL_OUT_REG     = 4;
    localparam int CTRL_SIGN_REG    = 5;
    localparam int CTRL_CLK_ENA     = 6;
    localparam int CTRL_CLEAR       = 7;
    localparam int CTRL_W           = 8;

    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h40;

    localparam int STAT_RES_SIGNED = 0;
    localparam int STAT_MODE       = 1;
    localparam int STAT_CLEARING   = 2;

    localparam int RES_HI_W = PROD_W - WB_DW;

endpackage : dms_pkg

// file: hdl/dms_smul.sv
`timescale 1ns/100ps
// Signed or unsigned multiplier of one width, full precision.
module dms_smul #(
    parameter int W = 18
) (
    input  wire logic [W-1:0]   a,
    input  wire logic [W-1:0]   b,
    input  wire logic           sign_a,
    input  wire logic           sign_b,
    output logic      [2*W-1:0] p
);
    logic signed [W:0]     ax;
    logic signed [W:0]     bx;
    logic signed [2*W+1:0] full;

    // One extra bit per operand lets one signed multiplier cover all four sign mixes.
    assign ax   = $signed({sign_a & a[W-1], a});
    assign bx   = $signed({sign_b & b[W-1], b});
    assign full = ax * bx;
    // The 2W low bits hold every mixed-sign product exactly, so no bit is lost.
    assign p    = full[2*W-1:0];

endmodule : dms_smul

// file: verif/dms_mult_assertions.sv
`timescale 1ns/100ps
module dms_mult_chk #(
    parameter int AW = dms_pkg::WIDE_W
) (
    input wire logic                      clk,
    input wire logic                      rst,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [dms_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic [dms_pkg::WB_DW-1:0] wb_dat_i,
    input wire logic [3:0]                wb_sel_i,
    input wire logic [dms_pkg::WB_DW-1:0] wb_dat_o,
    input wire logic                      wb_ack_o
);
    import dms_pkg::*;
    logic [CTRL_W-1:0] ctrl_r;
    wire               rd = wb_ack_o && !wb_we_i;
    // Status bits are judged against what software asked for, not against the datapath.
    always_ff @(posedge clk) begin
        if (rst)
            ctrl_r <= CTRL_RESET;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL)
            ctrl_r <= wb_dat_i[CTRL_W-1:0];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (!wb_stb_i |=> !wb_ack_o) else $error("stray ack");
    a_opa_width: assert property (rd && wb_adr_i == OFS_OPA |-> wb_dat_o[WB_DW-1:AW] == '0)
        else $error("operand too wide");
    a_hi_width: assert property (rd && wb_adr_i == OFS_RES_HI |-> wb_dat_o[WB_DW-1:RES_HI_W] == '0)
        else $error("result too wide");
    a_status_sign: assert property (rd && wb_adr_i == OFS_STATUS |->
        wb_dat_o[STAT_RES_SIGNED] == (ctrl_r[CTRL_SIGN_A] | ctrl_r[CTRL_SIGN_B])) else $error("bad sign");
    a_status_mode: assert property (rd && wb_adr_i == OFS_STATUS |->
        wb_dat_o[STAT_MODE] == ctrl_r[CTRL_MODE_NARROW]) else $error("bad mode");
    a_data_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
    c_narrow: cover property (rd && ctrl_r[CTRL_MODE_NARROW]);
    c_clear: cover property (rd && ctrl_r[CTRL_CLEAR]);
    c_hold: cover property (rd && !ctrl_r[CTRL_CLK_ENA]);
endmodule : dms_mult_chk

bind dms_mult dms_mult_chk #(.AW(AW)) u_chk (.*);

// file: verif/dms_fabric.sv
`timescale 1ns/100ps
// Stands in for the fabric logic that feeds operands and collects products.
module dms_fabric (
    input  wire logic                      clk,
    input  wire logic [dms_pkg::WB_DW-1:0] wb_dat_o,
    input  wire logic                      wb_ack_o,
    output logic                           wb_cyc_i,
    output logic                           wb_stb_i,
    output logic                           wb_we_i,
    output logic      [dms_pkg::WB_AW-1:0] wb_adr_i,
    output logic      [dms_pkg::WB_DW-1:0] wb_dat_i,
    output logic      [3:0]                wb_sel_i
);
    import dms_pkg::*;
    int tmo = 0;
    initial {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    task automatic xfer(input logic w, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d,
                        output logic [WB_DW-1:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) tmo++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // Released data does not keep its last value, so a lazy sampler is caught.
        wb_dat_i <= ~d;
    endtask : xfer
endmodule : dms_fabric

// file: verif/dms_mult_test.sv
`timescale 1ns/100ps
module dms_mult_test;
    import dms_pkg::*;
    typedef struct {logic [7:0] c; logic [17:0] a; logic [17:0] b; logic [35:0] p;} dms_row_s;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    logic             wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [WB_AW-1:0] wb_adr_i;
    logic [WB_DW-1:0] wb_dat_i, wb_dat_o, q;
    logic [3:0]       wb_sel_i;
    int               error_cnt = 0;
    int               total_checks = 0;
    // Both narrow halves share one sign pair, so each narrow row keeps like-signed halves.
    dms_row_s rows [6] = '{
        '{8'h40, 18'h3FFFF, 18'h3FFFF, 36'hFFFF80001},
        '{8'h46, 18'h3FFFF, 18'h3FFFF, 36'h000000001},
        '{8'h42, 18'h3FFFF, 18'h00002, 36'hFFFFFFFFE},
        '{8'h44, 18'h00002, 18'h20000, 36'hFFFFC0000},
        '{8'h41, 18'h007FF, 18'h005FF, 36'h0001BFC01},
        '{8'h47, 18'h201FF, 18'h005FF, 36'hFF8000001}};
    initial forever #20 clk = ~clk;
    dms_mult   dut (.*);
    dms_fabric fab (.*);
    task automatic check(input logic [WB_DW-1:0] seen, input logic [WB_DW-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test;
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic rw(input logic w, input logic [WB_AW-1:0] a, input logic [WB_DW-1:0] d);
        fab.xfer(w, a, d, q);
        if (fab.tmo > 0) begin
            error_cnt++;
            end_of_test();
        end
    endtask : rw
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rw(1'b0, OFS_CTRL, '0);
        check(q, 32'(CTRL_RESET));
        foreach (rows[i]) begin
            rw(1'b1, OFS_CTRL, 32'(rows[i].c));
            rw(1'b1, OFS_OPA, 32'(rows[i].a));
            rw(1'b1, OFS_OPB, 32'(rows[i].b));
            rw(1'b0, OFS_RES_LO, '0);
            check(q, rows[i].p[31:0]);
            rw(1'b0, OFS_RES_HI, '0);
            check(q, 32'(rows[i].p[35:32]));
        end
        rw(1'b1, OFS_CTRL, 32'h43);
        rw(1'b0, OFS_STATUS, '0);
        check(q, 32'h3);
        rw(1'b0, 8'h40, '0);
        check(q, '0);
        rw(1'b1, OFS_CTRL, 32'h58);
        rw(1'b1, OFS_OPA, 32'h3);
        rw(1'b1, OFS_OPB, 32'h5);
        rw(1'b0, OFS_RES_LO, '0);
        check(q, 32'hF);
        rw(1'b1, OFS_CTRL, 32'h18);
        rw(1'b1, OFS_OPA, 32'h7);
        rw(1'b0, OFS_RES_LO, '0);
        check(q, 32'hF);
        rw(1'b1, OFS_CTRL, 32'h98);
        rw(1'b0, OFS_RES_LO, '0);
        check(q, '0);
        rw(1'b1, OFS_CTRL, 32'h58);
        rw(1'b0, OFS_RES_LO, '0);
        check(q, 32'h23);
        // The sign stage holds its old pair while the enable is low, so only the staged signs are applied.
        rw(1'b1, OFS_CTRL, 32'h62);
        rw(1'b1, OFS_OPA, 32'h3FFFF);
        rw(1'b1, OFS_OPB, 32'h2);
        rw(1'b1, OFS_CTRL, 32'h24);
        rw(1'b0, OFS_RES_LO, '0);
        check(q, 32'hFFFFFFFE);
        rw(1'b0, OFS_RES_HI, '0);
        check(q, 32'hF);
        // A reset in mid-run must bring back the reset control word and clear operand A.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rw(1'b0, OFS_CTRL, '0);
        check(q, 32'(CTRL_RESET));
        rw(1'b0, OFS_OPA, '0);
        check(q, '0);
        end_of_test();
    end
endmodule : dms_mult_test
